// >>> hw/bsfp_pkg.sv
// shared constants and types for the bitstream frame parser
// What this block does
// R01: compression only on frame data, never block memory
// R02: source zero-pads frames on left to 64 bits
// R03: source zero-pads compressed frames right to bytes
// R04: order: comment, preamble header, setup, data frames
// R05: signature then comment skipped, kept out of CRC
// R06: lock on preamble, skip dummy, neither in CRC
// R07: command: opcode, compare flag, 23-bit zero info
// R08: CRC clear command clears CRC, frame+dummy excluded
// R09: identity command starts CRC, checks 32-bit ID
// R10: first control command loads control word zero
// R11: second control command loads control word one
// R12: dictionary command stores sixteen patterns for decompression
// R13: pointer set skips 16 zeros, loads 16-bit address
// R14: auto-increment carries dummy enable, definition, count
// R15: frame count ends command, first block 32
// R16: each frame with parity written at pointer
// R17: ones padding after frames and CRC discarded
// R18: per-frame CRC when compare-at-end flag zero
// R19: compare flag one enables CRC comparison
// R20: mismatch or unknown opcode aborts with error flag
// R21: pointer reset returns pointer to initial address
package bsfp_pkg;
	// register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_CW0 = 8'h08;
	localparam logic [7:0] A_CW1 = 8'h0c;
	localparam logic [7:0] A_FADDR = 8'h10;
	localparam logic [7:0] A_CRC = 8'h14;
	localparam logic [7:0] A_FCNT = 8'h18;
	// control fields and reset value
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CMP_BIT = 1;
	localparam int CTRL_RST_BIT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// status fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_ERR_LSB = 4;
	localparam int ST_CRCON_BIT = 9;
	localparam int ST_LOAD_BIT = 10;
	// error flag positions
	localparam int ERR_SIG = 0;
	localparam int ERR_OP = 1;
	localparam int ERR_ID = 2;
	localparam int ERR_CRC = 3;
	localparam int ERR_INFO = 4;
	// opcodes
	localparam logic [7:0] OP_CRC_CLR = 8'h3b;
	localparam logic [7:0] OP_ID = 8'he2;
	localparam logic [7:0] OP_ABSENT = 8'hff;
	localparam logic [7:0] OP_CW0 = 8'h22;
	localparam logic [7:0] OP_CW1 = 8'h23;
	localparam logic [7:0] OP_DICT = 8'h02;
	localparam logic [7:0] OP_FADDR = 8'hb4;
	localparam logic [7:0] OP_AINC = 8'hb8;
	localparam logic [7:0] OP_FRST = 8'h46;
	// stream constants
	localparam logic [31:0] PREAMBLE = 32'hffffbdb3;
	localparam logic [15:0] WORD_BYTES = 16'h0004;
	localparam logic [3:0] DUMMY_DEFAULT = 4'h4;
	localparam logic [15:0] DICT_BYTES = 16'h0010;
	localparam logic [15:0] CRC_BYTES = 16'h0002;
	localparam logic [15:0] FADDR_INIT = 16'h8000;
	localparam logic [15:0] FIRST_BLOCK_FRAMES = 16'h0020;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// parser states
	typedef enum logic [3:0] {
		S_SIG = 4'b0000,
		S_HUNT = 4'b0001,
		S_PDUM = 4'b0010,
		S_CMD = 4'b0011,
		S_SKIP = 4'b0100,
		S_ID = 4'b0101,
		S_CW0 = 4'b0110,
		S_CW1 = 4'b0111,
		S_DICT = 4'b1000,
		S_ADDR = 4'b1001,
		S_AINC = 4'b1010,
		S_FRAME = 4'b1011,
		S_CRC = 4'b1100,
		S_DUMMY = 4'b1101,
		S_ERR = 4'b1110
	} bsfp_state_t;
endpackage

// >>> hw/bsfp_crc_if.sv
// link between the parser and its running CRC engine
`timescale 1ns/1ps
interface bsfp_crc_if;
	logic clr;
	logic en;
	logic [7:0] data;
	logic [15:0] crc;
	modport engine (input clr, input en, input data, output crc);
	modport user (output clr, output en, output data, input crc);
endinterface

// >>> hw/bsfp_crc.sv
// running 16-bit CRC over bytes, most significant bit first
`timescale 1ns/1ps
module bsfp_crc import bsfp_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// parser side
	bsfp_crc_if.engine crc_io
);
	logic [15:0] crc_reg;

	// one byte step of the polynomial division
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// clear wins over accumulate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_reg <= CRC_INIT;
		end else if (crc_io.clr) begin
			crc_reg <= CRC_INIT;
		end else if (crc_io.en) begin
			crc_reg <= crc_step(crc_reg, crc_io.data);
		end
	end

	assign crc_io.crc = crc_reg;
endmodule

// >>> hw/bsfp_top.sv
// bitstream frame parser with wishbone register access
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module bsfp_top import bsfp_pkg::*; #(
	parameter logic [31:0] SIGNATURE = 32'h5a3c0f96, // value arbitrary
	parameter logic [31:0] DEVICE_ID = 32'h01234567, // value arbitrary
	parameter logic [15:0] FRAME_BYTES = 16'h0010
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// bitstream byte input
	input wire logic src_valid,
	input wire logic [7:0] src_data,
	output logic src_ready,
	// configuration memory write port
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_offset,
	output logic [15:0] mem_data,
	output logic [1:0] mem_strb,
	// status
	output logic cfg_error
);
	logic [1:0] rst_sync;
	logic rst_n;
	bsfp_state_t state_reg;
	logic [1:0] ctrl_reg;
	logic restart;
	logic [15:0] cnt_reg;
	logic [31:0] word_reg;
	logic [31:0] wnext;
	logic take;
	logic crc_on_reg;
	logic [4:0] err_reg;
	logic [31:0] cw0_reg;
	logic [31:0] cw1_reg;
	logic [7:0] dict_mem [0:15];
	logic [15:0] faddr_reg;
	logic [15:0] frames_left_reg;
	logic [15:0] out_cnt_reg;
	logic [15:0] fcnt_reg;
	logic ai_cmp_reg;
	logic ai_end_reg;
	logic [3:0] dummy_n_reg;
	logic [3:0] skip_n_reg;
	logic cmp_mode_reg;
	logic [15:0] step;
	logic frame_end;
	logic last_frame;
	logic crc_hit;
	logic [7:0] opc;
	logic wb_req;

	bsfp_crc_if crc_bus ();

	bsfp_crc u_crc (
		.clk(sys_clk),
		.rst_n(rst_n),
		.crc_io(crc_bus.engine)
	);

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// byte handshake and word assembly
	assign take = src_valid && src_ready;
	assign wnext = {word_reg[23:0], src_data};
	assign opc = wnext[31:24];
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign restart = wb_req && wb_we_i && (wb_adr_i == A_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_RST_BIT];
	// compressed bytes expand to two output bytes
	assign step = cmp_mode_reg ? 16'h0002 : 16'h0001;
	assign frame_end = (state_reg == S_FRAME) && take && (out_cnt_reg + step >= FRAME_BYTES);
	assign last_frame = (frames_left_reg == 16'h0001);
	assign crc_hit = (wnext[15:0] == crc_bus.crc);

	// crc engine control
	always_comb begin
		crc_bus.data = src_data;
		crc_bus.clr = 1'b0;
		crc_bus.en = 1'b0;
		if (restart) begin
			crc_bus.clr = 1'b1;
		end else if (take) begin
			// header, signature, comment and received crc stay out
			crc_bus.en = (crc_on_reg || (state_reg == S_CMD && cnt_reg == 16'h0 &&
				(src_data == OP_ID || src_data == OP_ABSENT))) && state_reg != S_CRC; // R05 R06 R09
			if (state_reg == S_CMD && cnt_reg == 16'h3 && opc == OP_CRC_CLR) begin
				crc_bus.clr = 1'b1; // R08
			end
			if (state_reg == S_CRC && cnt_reg == 16'h1) begin
				crc_bus.clr = 1'b1; // R18
			end
		end
	end

	// crc accumulation window
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_on_reg <= 1'b0;
		end else if (restart) begin
			crc_on_reg <= 1'b0;
		end else if (take && state_reg == S_CMD && cnt_reg == 16'h0 && (src_data == OP_ID || src_data == OP_ABSENT)) begin
			// opens on the first opcode byte so the rest of the identity frame is summed too
			crc_on_reg <= 1'b1; // R09
		end else if (take && state_reg == S_CMD && cnt_reg == 16'h3 && opc == OP_CRC_CLR) begin
			crc_on_reg <= 1'b0; // R08
		end
	end

	// word shift register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_reg <= 32'h0;
		end else if (take) begin
			word_reg <= wnext;
		end
	end

	// main parsing sequence
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_SIG;
			cnt_reg <= 16'h0;
			skip_n_reg <= 4'h0;
			err_reg <= 5'h0;
		end else if (restart) begin
			state_reg <= S_SIG;
			cnt_reg <= 16'h0;
			err_reg <= 5'h0;
		end else if (take) begin
			cnt_reg <= cnt_reg + 16'h1;
			unique case (state_reg)
				S_SIG: begin
					if (cnt_reg == 16'h3) begin
						cnt_reg <= 16'h0;
						if (wnext == SIGNATURE) begin
							state_reg <= S_HUNT; // R05
						end else begin
							state_reg <= S_ERR;
							err_reg[ERR_SIG] <= 1'b1;
						end
					end
				end
				S_HUNT: begin
					// comment bytes are dropped until the preamble lines up
					cnt_reg <= 16'h0;
					if (wnext == PREAMBLE) begin
						state_reg <= S_PDUM; // R06
					end
				end
				S_PDUM: begin
					if (cnt_reg == WORD_BYTES - 16'h1) begin
						cnt_reg <= 16'h0;
						state_reg <= S_CMD; // R06 R04
					end
				end
				S_CMD: begin
					if (cnt_reg == 16'h3) begin
						cnt_reg <= 16'h0;
						if (wnext[22:0] != 23'h0 && opc != OP_AINC && opc != OP_FADDR && opc != OP_ABSENT) begin
							state_reg <= S_ERR; // R07
							err_reg[ERR_INFO] <= 1'b1;
						end else begin
							unique case (opc)
								OP_CRC_CLR: begin
									state_reg <= S_SKIP; // R08
									skip_n_reg <= DUMMY_DEFAULT;
								end
								OP_ABSENT: begin
									state_reg <= S_SKIP; // R09
									skip_n_reg <= DUMMY_DEFAULT;
								end
								OP_ID: state_reg <= S_ID;
								OP_CW0: state_reg <= S_CW0;
								OP_CW1: state_reg <= S_CW1;
								OP_DICT: state_reg <= S_DICT;
								OP_FADDR: state_reg <= S_ADDR;
								OP_AINC: state_reg <= S_AINC;
								OP_FRST: state_reg <= S_CMD;
								default: begin
									state_reg <= S_ERR; // R20
									err_reg[ERR_OP] <= 1'b1;
								end
							endcase
						end
					end
				end
				S_SKIP: begin
					if (cnt_reg == {12'h0, skip_n_reg} - 16'h1) begin
						cnt_reg <= 16'h0;
						state_reg <= S_CMD;
					end
				end
				S_ID: begin
					if (cnt_reg == 16'h3) begin
						cnt_reg <= 16'h0;
						if (wnext == DEVICE_ID) begin
							state_reg <= S_CMD; // R09
						end else begin
							state_reg <= S_ERR; // R20
							err_reg[ERR_ID] <= 1'b1;
						end
					end
				end
				S_CW0, S_CW1, S_ADDR: begin
					if (cnt_reg == 16'h3) begin
						cnt_reg <= 16'h0;
						state_reg <= S_CMD;
					end
				end
				S_DICT: begin
					if (cnt_reg == DICT_BYTES - 16'h1) begin
						cnt_reg <= 16'h0;
						state_reg <= S_CMD;
					end
				end
				S_AINC: begin
					if (cnt_reg == 16'h1) begin
						cnt_reg <= 16'h0;
						if (wnext[15:0] == 16'h0) begin
							state_reg <= S_CMD;
						end else if (faddr_reg == FADDR_INIT && wnext[15:0] != FIRST_BLOCK_FRAMES) begin
							state_reg <= S_ERR; // R15
							err_reg[ERR_INFO] <= 1'b1;
						end else begin
							state_reg <= S_FRAME;
						end
					end
				end
				S_FRAME: begin
					cnt_reg <= 16'h0;
					if (frame_end) begin
						state_reg <= (!ai_end_reg || last_frame) ? S_CRC : S_DUMMY; // R18
					end
				end
				S_CRC: begin
					if (cnt_reg == CRC_BYTES - 16'h1) begin
						cnt_reg <= 16'h0;
						if (ai_cmp_reg && !crc_hit) begin
							state_reg <= S_ERR; // R19 R20
							err_reg[ERR_CRC] <= 1'b1;
						end else begin
							state_reg <= S_DUMMY;
						end
					end
				end
				S_DUMMY: begin
					if (cnt_reg == {12'h0, dummy_n_reg} - 16'h1) begin
						cnt_reg <= 16'h0;
						state_reg <= (frames_left_reg == 16'h0) ? S_CMD : S_FRAME; // R17
					end
				end
				S_ERR: begin
					cnt_reg <= 16'h0; // further bytes are sunk, nothing written
				end
				default: begin
					state_reg <= S_ERR;
				end
			endcase
		end
	end

	// control words
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cw0_reg <= 32'h0;
			cw1_reg <= 32'h0;
		end else if (take && cnt_reg == 16'h3) begin
			if (state_reg == S_CW0) begin
				cw0_reg <= wnext; // R10
			end
			if (state_reg == S_CW1) begin
				cw1_reg <= wnext; // R11
			end
		end
	end

	// dictionary capture, first byte received is entry fifteen
	always_ff @(posedge sys_clk) begin
		if (take && state_reg == S_DICT) begin
			dict_mem[4'hf - cnt_reg[3:0]] <= src_data; // R12
		end
	end

	// auto-increment options, counts and frame pointer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			faddr_reg <= FADDR_INIT;
			frames_left_reg <= 16'h0;
			out_cnt_reg <= 16'h0;
			fcnt_reg <= 16'h0;
			ai_cmp_reg <= 1'b0;
			ai_end_reg <= 1'b0;
			dummy_n_reg <= DUMMY_DEFAULT;
			cmp_mode_reg <= 1'b0;
		end else if (restart) begin
			faddr_reg <= FADDR_INIT;
			frames_left_reg <= 16'h0;
			out_cnt_reg <= 16'h0;
			fcnt_reg <= 16'h0;
		end else if (take) begin
			if (state_reg == S_CMD && cnt_reg == 16'h3 && opc == OP_FRST) begin
				faddr_reg <= FADDR_INIT; // R21
			end
			if (state_reg == S_CMD && cnt_reg == 16'h3 && opc == OP_AINC) begin
				ai_cmp_reg <= wnext[23]; // R19
				ai_end_reg <= wnext[22]; // R18
				// a set definition bit (bit 20) with bit 21 clear takes the low nibble as the padding size
				dummy_n_reg <= (wnext[21] || !wnext[20]) ? DUMMY_DEFAULT : wnext[3:0]; // R14
				cmp_mode_reg <= ctrl_reg[CTRL_CMP_BIT]; // R01
			end
			if (state_reg == S_ADDR && cnt_reg == 16'h3) begin
				faddr_reg <= wnext[15:0]; // R13
			end
			if (state_reg == S_AINC && cnt_reg == 16'h1) begin
				frames_left_reg <= wnext[15:0]; // R15
				out_cnt_reg <= 16'h0;
			end
			if (state_reg == S_FRAME) begin
				out_cnt_reg <= frame_end ? 16'h0 : out_cnt_reg + step;
				if (frame_end) begin
					faddr_reg <= faddr_reg + 16'h1; // R15
					frames_left_reg <= frames_left_reg - 16'h1;
					fcnt_reg <= fcnt_reg + 16'h1;
				end
			end
		end
	end

	// frame data writes to configuration memory
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_we <= 1'b0;
			mem_addr <= 16'h0;
			mem_offset <= 16'h0;
			mem_data <= 16'h0;
			mem_strb <= 2'h0;
		end else begin
			mem_we <= take && state_reg == S_FRAME && !restart; // R16
			if (take && state_reg == S_FRAME) begin
				mem_addr <= faddr_reg; // R16
				mem_offset <= out_cnt_reg;
				if (cmp_mode_reg) begin
					mem_data <= {dict_mem[src_data[7:4]], dict_mem[src_data[3:0]]}; // R12
					mem_strb <= 2'h3;
				end else begin
					mem_data <= {8'h0, src_data};
					mem_strb <= 2'h1;
				end
			end
		end
	end

	// source handshake and error output
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_ready <= 1'b0;
			cfg_error <= 1'b0;
		end else begin
			src_ready <= ctrl_reg[CTRL_EN_BIT] && !restart;
			cfg_error <= (state_reg == S_ERR); // R20
		end
	end

	// control register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wb_req && wb_we_i && wb_adr_i == A_CTRL && wb_sel_i[0]) begin
			ctrl_reg <= wb_dat_i[1:0];
		end
	end

	// wishbone ack and read data, one wait state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					A_CTRL: wb_dat_o <= {30'h0, ctrl_reg};
					A_STAT: wb_dat_o <= {21'h0, state_reg == S_FRAME, crc_on_reg, err_reg, state_reg};
					A_CW0: wb_dat_o <= cw0_reg;
					A_CW1: wb_dat_o <= cw1_reg;
					A_FADDR: wb_dat_o <= {16'h0, faddr_reg};
					A_CRC: wb_dat_o <= {16'h0, crc_bus.crc};
					A_FCNT: wb_dat_o <= {16'h0, fcnt_reg};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end
endmodule

// >>> dv/bsfp_checker.sv
// concurrent checks on the frame parser top ports
`timescale 1ns/1ps
module bsfp_checker import bsfp_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// stream and memory port
	input wire logic src_valid,
	input wire logic src_ready,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_offset,
	input wire logic [15:0] mem_data,
	input wire logic [1:0] mem_strb,
	input wire logic cfg_error
);
	logic restart_w;
	logic [15:0] addr_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// restart request taken on the bus
	assign restart_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == A_CTRL && wb_sel_i[0]
		&& wb_dat_i[CTRL_RST_BIT];
	// address of the last memory write
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addr_reg <= 16'h0000;
		end else if (mem_we) begin
			addr_reg <= mem_addr;
		end
	end
	a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack did not follow request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_we_after_take: assert property (mem_we |-> $past(src_valid && src_ready))
		else $error("memory write without a byte taken");
	a_error_no_write: assert property (cfg_error |-> !mem_we)
		else $error("memory written while in error");
	a_error_until_restart: assert property ($fell(cfg_error) |-> $past(restart_w) || $past(restart_w, 2) || $past(restart_w, 3))
		else $error("error flag dropped without restart");
	a_ready_drop_restart: assert property (restart_w |-> ##[1:2] !src_ready)
		else $error("source still ready after restart");
	a_strobe_kind: assert property (mem_we |-> mem_strb == 2'b01 || mem_strb == 2'b11)
		else $error("bad lane enables");
	a_plain_high_zero: assert property (mem_we && mem_strb == 2'b01 |-> mem_data[15:8] == 8'h00)
		else $error("plain byte with upper lane set");
	a_frame_addr_stable: assert property (mem_we && mem_offset != 16'h0000 |-> mem_addr == addr_reg)
		else $error("frame address moved inside a frame");
	a_quiet_after_reset: assert property ($rose(resetn) |-> !src_ready && !mem_we && !cfg_error && !wb_ack_o)
		else $error("outputs active out of reset");
	c_packed_write: cover property (mem_we && mem_strb == 2'b11);
	c_error: cover property ($rose(cfg_error));
	c_restart: cover property (restart_w);
endmodule
bind bsfp_top bsfp_checker chk (
	.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .src_valid(src_valid),
	.src_ready(src_ready), .mem_we(mem_we), .mem_addr(mem_addr), .mem_offset(mem_offset), .mem_data(mem_data),
	.mem_strb(mem_strb), .cfg_error(cfg_error)
);

// >>> dv/bsfp_src.sv
// byte source standing in for the external bitstream host
`timescale 1ns/1ps
module bsfp_src (
	// clock
	input wire logic clk,
	// stream
	input wire logic src_ready,
	input wire logic slow,
	output logic src_valid,
	output logic [7:0] src_data
);
	logic [7:0] q[$];
	initial begin
		src_valid = 1'b0;
		src_data = 8'h00;
	end
	// bytes leave strictly in queued order, each held until taken, a gap after each when slow
	always @(posedge clk) begin
		if (src_valid && src_ready) begin
			void'(q.pop_front());
		end
		if (src_valid && !src_ready) begin
			src_valid <= 1'b1;
		end else if (q.size() != 0 && !(slow && src_valid)) begin
			src_valid <= 1'b1;
			src_data <= q[0];
		end else begin
			src_valid <= 1'b0;
			src_data <= ~src_data; // idle line inverts the byte each cycle, so every second idle cycle shows the last byte again
		end
	end
endmodule

// >>> dv/bsfp_bench.sv
// self-checking bench for the bitstream frame parser
`timescale 1ns/1ps
module bsfp_bench import bsfp_pkg::*; ;
	localparam logic [31:0] SIG = 32'h5a3c0f96; // value arbitrary
	localparam logic [31:0] ID = 32'h01234567; // value arbitrary
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dati = 32'h00000000;
	logic slow = 1'b1;
	logic [31:0] dato;
	logic ack;
	logic src_valid;
	logic [7:0] src_data;
	logic src_ready;
	logic mem_we;
	logic [15:0] mem_addr;
	logic [15:0] mem_offset;
	logic [15:0] mem_data;
	logic [1:0] mem_strb;
	logic cfg_error;
	logic [49:0] expq[$];
	logic [15:0] crc = 16'h0000;
	logic crc_on = 1'b0;
	logic [31:0] rd;
	int mismatches = 0;
	int total_checks = 0;
	bsfp_top #(.SIGNATURE(SIG), .DEVICE_ID(ID), .FRAME_BYTES(16'h0010)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .src_valid(src_valid),
		.src_data(src_data), .src_ready(src_ready), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_offset(mem_offset), .mem_data(mem_data), .mem_strb(mem_strb), .cfg_error(cfg_error)
	);
	bsfp_src src (.clk(sys_clk), .src_ready(src_ready), .slow(slow), .src_valid(src_valid), .src_data(src_data));
	// clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dati <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		r = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("bus answer", 64'(n < 100), 64'h1);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h00000000, r);
		check(nm, 64'(r), 64'(e));
	endtask
	// queue a stream byte and, while crc_on is set, fold it into the expected crc
	task automatic sb(input logic [7:0] b);
		src.q.push_back(b);
		if (crc_on) begin
			crc = crc ^ {b, 8'h00};
			for (int i = 0; i < 8; i++) crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
		end
	endtask
	task automatic sw(input logic [31:0] w);
		for (int i = 3; i >= 0; i--) sb(w[i*8 +: 8]);
	endtask
	task automatic scrc(input logic bad);
		src.q.push_back(crc[15:8]);
		src.q.push_back(crc[7:0] ^ {7'h00, bad});
		crc = 16'h0000;
	endtask
	// signature, comment, preamble, dummy, crc clear and its dummy
	task automatic hdr(input logic [31:0] s);
		crc_on = 1'b0;
		sw(s);
		sb(8'h68);
		sb(8'h00);
		sw(PREAMBLE);
		sw(32'hffffffff);
		sw({OP_CRC_CLR, 24'h000000});
		sw(32'hffffffff);
		crc = 16'h0000;
		crc_on = 1'b1;
	endtask
	// one frame: 16 plain bytes, or 8 packed bytes of nibble indices
	task automatic frm(input logic [15:0] a, input logic comp, input int k);
		logic [7:0] b;
		for (int i = 0; i < (comp ? 8 : 16); i++) begin
			b = 8'(i * 37 + k);
			sb(b);
			if (comp) expq.push_back({a, 16'(i * 2), 8'ha0 + 8'(b[7:4]), 8'ha0 + 8'(b[3:0]), 2'b11});
			else expq.push_back({a, 16'(i), 8'h00, b, 2'b01});
		end
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (src.q.size() != 0 && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (4) @(posedge sys_clk);
		check("stream drained", 64'(n < 5000), 64'h1);
	endtask
	// memory writes against expectations, packed writes advance the offset by two
	always @(posedge sys_clk) begin
		logic [49:0] e;
		if (mem_we === 1'b1) begin
			e = expq.size() != 0 ? expq.pop_front() : 50'h0;
			check("mem write", 64'({mem_addr, mem_offset, mem_data, mem_strb}), 64'(e));
		end
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check("ready before enable", 64'(src_ready), 64'h0);
		rdc("ctrl", A_CTRL, 32'h0);
		wb(1'b1, 8'h40, 32'hffffffff, rd);
		rdc("unmapped", 8'h40, 32'h0);
		wb(1'b1, A_STAT, 32'hffffffff, rd);
		rdc("status", A_STAT, 32'h0);
		wb(1'b1, A_CTRL, 32'h00000001, rd);
		hdr(SIG);
		sw({OP_ID, 24'h0});
		sw(ID);
		sw({OP_CW0, 24'h0});
		sw(32'hc0de0001);
		sw({OP_CW1, 24'h0});
		sw(32'h5eed0002);
		sw({OP_DICT, 24'h0});
		for (int k = 0; k < 16; k++) sb(8'haf - 8'(k));
		sw({OP_FADDR, 24'h0});
		sw({16'h0000, FADDR_INIT});
		sw({OP_AINC, 24'hd00004});
		sb(8'h00);
		sb(8'h20);
		for (int k = 0; k < 32; k++) begin
			frm(FADDR_INIT + 16'(k), 1'b0, k);
			if (k == 31) scrc(1'b0);
			sw(32'hffffffff);
		end
		drain();
		rdc("pointer", A_FADDR, 32'h00008020);
		rdc("frames", A_FCNT, 32'h00000020);
		rdc("word0", A_CW0, 32'hc0de0001);
		rdc("word1", A_CW1, 32'h5eed0002);
		sw({OP_FRST, 24'h0});
		drain();
		rdc("pointer reset", A_FADDR, 32'h00008000);
		rdc("running crc", A_CRC, {16'h0000, crc});
		check("no error", 64'(cfg_error), 64'h0);
		// packed frames with a crc after each, the second one corrupted
		slow <= 1'b0;
		wb(1'b1, A_CTRL, 32'h00000003, rd);
		sw({OP_FADDR, 24'h0});
		sw(32'h00001234);
		sw({OP_AINC, 24'h900002});
		sb(8'h00);
		sb(8'h02);
		for (int k = 0; k < 2; k++) begin
			frm(16'h1234 + 16'(k), 1'b1, k);
			scrc(k == 1);
			sb(8'hff);
			sb(8'hff);
		end
		drain();
		check("crc abort", 64'(cfg_error), 64'h1);
		wb(1'b0, A_STAT, 32'h0, rd);
		check("crc error bit", 64'(rd[ST_ERR_LSB + ERR_CRC]), 64'h1);
		// restart, then one faulty stream per case
		for (int c = 0; c < 5; c++) begin
			wb(1'b1, A_CTRL, 32'h00000005, rd);
			hdr(c == 4 ? ~SIG : SIG);
			if (c == 0) sw({OP_ID, 24'h0});
			if (c == 0) sw(~ID);
			if (c == 1) sw(32'h77000000);
			if (c == 2) sw({OP_CW0, 24'h000001});
			if (c == 3) begin
				sw(32'hffffffff);
				sw(32'hffffffff);
				sw({OP_FADDR, 24'h0});
				sw({16'h0000, FADDR_INIT});
				sw({OP_AINC, 24'hd00004});
				sb(8'h00);
				sb(8'h10);
			end
			drain();
			wb(1'b0, A_STAT, 32'h0, rd);
			check("fault error bit", 64'(rd[ST_ERR_LSB + (c == 0 ? ERR_ID : c == 1 ? ERR_OP : c == 4 ? ERR_SIG : ERR_INFO)]), 64'h1);
		end
		check("writes left", 64'(expq.size()), 64'h0);
		close_out();
	end
endmodule
